// file: src/msc_pkg.sv
// constants, encodings and state type for the multi-segment switch control block
// assumes a single 125 MHz sample clock shared by all users of the package
package msc_pkg;
  localparam int SEG_W = 4;
  localparam int NUM_SEG = 16;
  localparam int POS_W = 16;
  localparam int GAIN_W = 8;
  localparam int PL_W = 6;
  localparam int PL_DEPTH = 64;
  localparam int JUMP_W = 5;
  localparam int REP_W = 8;
  localparam int USEL_W = 2;
  localparam int NUM_USER = 4;
  localparam int DATA_W = SEG_W + POS_W + GAIN_W;
  localparam int GAP_W = 25;
  localparam int CLK_KHZ = 125000;
  localparam int SW_EQ_MS = 20;
  localparam int SW_DIFF_MS = 200;
  localparam int SW_EQ_CYC = SW_EQ_MS * CLK_KHZ;
  localparam int SW_DIFF_CYC = SW_DIFF_MS * CLK_KHZ;
  localparam logic [1:0] MODE_HOLD = 2'h0;
  localparam logic [1:0] MODE_ABRUPT = 2'h1;
  localparam logic [1:0] MODE_GAPLESS = 2'h2;
  localparam logic [1:0] MODE_PLAYLIST = 2'h3;
  localparam logic [1:0] NXT_NEXT = 2'h0;
  localparam logic [1:0] NXT_BLANK = 2'h1;
  localparam logic [1:0] NXT_ENDLESS = 2'h2;
  localparam logic [1:0] NXT_JUMP = 2'h3;
  localparam logic [SEG_W-1:0] RST_SEG = 4'h0;
  localparam logic [REP_W-1:0] REP_ONE = 8'h01;
  localparam logic [PL_W-1:0] PL_LAST = 6'h3F;
  typedef enum logic [2:0] {ST_LOAD, ST_PLAY, ST_GAP, ST_SCAN, ST_BLANK} msc_state_type;
endpackage : msc_pkg

// file: src/msc_switch_ctrl.sv
// multi-segment switch control: picks the segment and sample index that playback reads
// assumes all inputs synchronous to clk_in; sample memory and gain stage sit downstream
`timescale 1ns/1ps
module msc_switch_ctrl
  import msc_pkg::*;
#(
  parameter int unsigned GAP_EQ_CYC = SW_EQ_CYC,
  parameter int unsigned GAP_DIFF_CYC = SW_DIFF_CYC
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic rates_equal_in,
  input wire logic src_ext_in,
  input wire logic [USEL_W-1:0] user_sel_in,
  input wire logic [NUM_USER-1:0] user_conn_in,
  input wire logic exec_switch_in,
  input wire logic [SEG_W-1:0] target_seg_in,
  input wire logic [SEG_W-1:0] last_seg_in,
  input wire logic level_highest_in,
  input wire logic restart_in,
  input wire logic seg_we_in,
  input wire logic [SEG_W-1:0] seg_idx_in,
  input wire logic [POS_W-1:0] seg_len_in,
  input wire logic [GAIN_W-1:0] seg_crest_in,
  input wire logic pl_we_in,
  input wire logic [PL_W-1:0] pl_idx_in,
  input wire logic pl_en_in,
  input wire logic [SEG_W-1:0] pl_seg_in,
  input wire logic [REP_W-1:0] pl_rep_in,
  input wire logic [1:0] pl_next_in,
  input wire logic [JUMP_W-1:0] jump_to_entry_in,
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic [SEG_W-1:0] out_seg_out,
  output logic [POS_W-1:0] out_pos_out,
  output logic [GAIN_W-1:0] out_gain_out,
  output logic [SEG_W-1:0] cur_seg_out,
  output logic [PL_W-1:0] cur_entry_out,
  output logic gap_out,
  output logic blank_out,
  output logic pending_out,
  output logic fallback_out
);

  logic [POS_W-1:0] len_mem [NUM_SEG];
  logic [GAIN_W-1:0] crest_mem [NUM_SEG];
  logic pl_en_mem [PL_DEPTH];
  logic [SEG_W-1:0] pl_seg_mem [PL_DEPTH];
  logic [REP_W-1:0] pl_rep_mem [PL_DEPTH];
  logic [1:0] pl_next_mem [PL_DEPTH];
  logic [JUMP_W-1:0] pl_jump_mem [PL_DEPTH];

  msc_state_type st_r, st_nxt;
  logic [SEG_W-1:0] cur_seg_r, cur_seg_nxt;
  logic [SEG_W-1:0] load_seg_r, load_seg_nxt;
  logic [SEG_W-1:0] pend_seg_r, pend_seg_nxt;
  logic [SEG_W-1:0] tgt_prev_r, tgt_prev_nxt;
  logic [POS_W-1:0] pos_r, pos_nxt;
  logic [GAP_W-1:0] gap_cnt_r, gap_cnt_nxt;
  logic [PL_W-1:0] entry_r, entry_nxt;
  logic [PL_W-1:0] scan_cnt_r, scan_cnt_nxt;
  logic [REP_W-1:0] rep_left_r, rep_left_nxt;
  logic pend_r, pend_nxt;
  logic ext_prev_r, ext_prev_nxt;
  logic pl_prev_r, pl_prev_nxt;

  logic [1:0] mode_eff;
  logic pl_mode;
  logic ext_lvl;
  logic sw_evt;
  logic tgt_chg;
  logic [SEG_W-1:0] evt_seg;
  logic [SEG_W-1:0] base_seg;
  logic [POS_W-1:0] last_pos;
  logic [GAP_W-1:0] gap_len;
  logic [GAIN_W-1:0] max_crest;
  logic [GAIN_W-1:0] gain;
  logic emit;
  logic eos;
  logic fifo_in_ready;

  // table writes by the host; lengths and crest factors per segment, play-list per entry
  always_ff @(posedge clk_in)
  begin
    if (seg_we_in)
    begin
      len_mem[seg_idx_in] <= seg_len_in;
      crest_mem[seg_idx_in] <= seg_crest_in;
    end
    if (pl_we_in)
    begin
      pl_en_mem[pl_idx_in] <= pl_en_in;
      pl_seg_mem[pl_idx_in] <= pl_seg_in;
      pl_rep_mem[pl_idx_in] <= pl_rep_in;
      pl_next_mem[pl_idx_in] <= pl_next_in;
      pl_jump_mem[pl_idx_in] <= jump_to_entry_in;
    end
  end

  always_comb
  begin
    max_crest = '0;
    for (int i = 0; i < NUM_SEG; i++)
    begin
      if (crest_mem[i] > max_crest)
      begin
        max_crest = crest_mem[i];
      end
    end
    gain = level_highest_in ? max_crest : crest_mem[cur_seg_r];
  end

  // seamless modes fall back when rates differ: gapless acts abrupt, play-list acts hold
  always_comb
  begin
    mode_eff = mode_in;
    if (!rates_equal_in && mode_in == MODE_GAPLESS)
    begin
      mode_eff = MODE_ABRUPT;
    end
    else if (!rates_equal_in && mode_in == MODE_PLAYLIST)
    begin
      mode_eff = MODE_HOLD;
    end
  end

  assign pl_mode = (mode_eff == MODE_PLAYLIST);
  assign ext_lvl = user_conn_in[user_sel_in];
  assign sw_evt = pl_mode ? 1'b0 : (src_ext_in ? (ext_lvl & ~ext_prev_r) : exec_switch_in);
  // on the load cycle the segment being loaded is the one an external step counts from
  assign base_seg = (st_r == ST_LOAD) ? load_seg_r : cur_seg_r;
  assign evt_seg = src_ext_in ? ((base_seg == last_seg_in) ? RST_SEG : base_seg + 4'h1) : target_seg_in;
  assign tgt_chg = (target_seg_in != tgt_prev_r);
  assign gap_len = rates_equal_in ? GAP_W'(GAP_EQ_CYC) : GAP_W'(GAP_DIFF_CYC);
  // a zero length is played as one sample so the end point always exists
  assign last_pos = (len_mem[cur_seg_r] == '0) ? '0 : len_mem[cur_seg_r] - 16'h0001;
  assign emit = (st_r == ST_PLAY) && fifo_in_ready;
  assign eos = emit && (pos_r == last_pos);

  always_comb
  begin
    st_nxt = st_r;
    cur_seg_nxt = cur_seg_r;
    load_seg_nxt = load_seg_r;
    pend_seg_nxt = pend_seg_r;
    pend_nxt = pend_r;
    pos_nxt = pos_r;
    gap_cnt_nxt = gap_cnt_r;
    entry_nxt = entry_r;
    scan_cnt_nxt = scan_cnt_r;
    rep_left_nxt = rep_left_r;
    tgt_prev_nxt = target_seg_in;
    ext_prev_nxt = ext_lvl;
    pl_prev_nxt = pl_mode;
    if (emit)
    begin
      pos_nxt = eos ? '0 : pos_r + 16'h0001;
    end
    if ((pl_mode && !pl_prev_r) || (pl_mode && restart_in))
    begin
      st_nxt = ST_SCAN;
      entry_nxt = '0;
      scan_cnt_nxt = '0;
      pend_nxt = 1'b0;
    end
    else if (!pl_mode && pl_prev_r)
    begin
      st_nxt = ST_LOAD;
      load_seg_nxt = target_seg_in;
      pend_nxt = 1'b0;
    end
    else if (pl_mode)
    begin
      unique case (st_r)
        ST_SCAN:
        begin
          if (pl_en_mem[entry_r])
          begin
            st_nxt = ST_PLAY;
            cur_seg_nxt = pl_seg_mem[entry_r];
            rep_left_nxt = (pl_rep_mem[entry_r] == '0) ? REP_ONE : pl_rep_mem[entry_r];
            pos_nxt = '0;
          end
          else if (scan_cnt_r == PL_LAST)
          begin
            st_nxt = ST_BLANK; // nothing enabled: stay silent until restart or until play-list mode is left
          end
          else
          begin
            entry_nxt = entry_r + 6'h01;
            scan_cnt_nxt = scan_cnt_r + 6'h01;
          end
        end
        ST_PLAY:
        begin
          if (eos && pl_next_mem[entry_r] != NXT_ENDLESS)
          begin
            if (rep_left_r > REP_ONE)
            begin
              rep_left_nxt = rep_left_r - REP_ONE;
            end
            else
            begin
              unique case (pl_next_mem[entry_r])
                NXT_NEXT:
                begin
                  st_nxt = ST_SCAN;
                  entry_nxt = entry_r + 6'h01;
                  scan_cnt_nxt = '0;
                end
                NXT_BLANK:
                begin
                  st_nxt = ST_BLANK;
                end
                NXT_JUMP:
                begin
                  st_nxt = ST_SCAN;
                  entry_nxt = {1'b0, pl_jump_mem[entry_r]};
                  scan_cnt_nxt = '0;
                end
                NXT_ENDLESS:
                begin
                  st_nxt = ST_PLAY;
                end
              endcase
            end
          end
        end
        ST_LOAD, ST_GAP, ST_BLANK:
        begin
          st_nxt = st_r; // leaving only by restart or by leaving play-list mode above
        end
      endcase
    end
    else
    begin
      unique case (st_r)
        ST_LOAD:
        begin
          st_nxt = ST_PLAY;
          cur_seg_nxt = load_seg_r;
          pos_nxt = '0;
          // in hold and abrupt modes a request on the load cycle is not lost: it opens a new gap at once
          if ((mode_eff == MODE_HOLD && tgt_chg) || (mode_eff == MODE_ABRUPT && sw_evt))
          begin
            st_nxt = ST_GAP;
            load_seg_nxt = (mode_eff == MODE_HOLD) ? target_seg_in : evt_seg;
            gap_cnt_nxt = gap_len;
          end
        end
        ST_PLAY, ST_GAP:
        begin
          if (st_r == ST_GAP)
          begin
            gap_cnt_nxt = gap_cnt_r - 25'h0000001;
            if (gap_cnt_r <= 25'h0000001)
            begin
              st_nxt = ST_LOAD;
            end
          end
          if (mode_eff == MODE_HOLD && tgt_chg)
          begin
            st_nxt = ST_GAP;
            load_seg_nxt = target_seg_in;
            gap_cnt_nxt = gap_len;
          end
          else if (mode_eff == MODE_ABRUPT && sw_evt)
          begin
            st_nxt = ST_GAP;
            load_seg_nxt = evt_seg;
            gap_cnt_nxt = gap_len;
          end
          else if (mode_eff == MODE_GAPLESS && st_r == ST_PLAY)
          begin
            if (eos && pend_r)
            begin
              cur_seg_nxt = pend_seg_r;
              pend_nxt = 1'b0;
            end
            // a request landing on the end cycle is kept for the next end
            if (sw_evt || (!src_ext_in && tgt_chg))
            begin
              pend_nxt = 1'b1;
              pend_seg_nxt = sw_evt ? evt_seg : target_seg_in;
            end
          end
          if (mode_eff != MODE_GAPLESS)
          begin
            pend_nxt = 1'b0;
          end
        end
        ST_SCAN, ST_BLANK:
        begin
          st_nxt = ST_LOAD;
          load_seg_nxt = target_seg_in;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_r <= ST_LOAD;
      cur_seg_r <= RST_SEG;
      load_seg_r <= RST_SEG;
      pend_seg_r <= RST_SEG;
      tgt_prev_r <= RST_SEG;
      pend_r <= 1'b0;
      pos_r <= '0;
      gap_cnt_r <= '0;
      entry_r <= '0;
      scan_cnt_r <= '0;
      rep_left_r <= REP_ONE;
      ext_prev_r <= 1'b0;
      pl_prev_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cur_seg_r <= cur_seg_nxt;
      load_seg_r <= load_seg_nxt;
      pend_seg_r <= pend_seg_nxt;
      tgt_prev_r <= tgt_prev_nxt;
      pend_r <= pend_nxt;
      pos_r <= pos_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      entry_r <= entry_nxt;
      scan_cnt_r <= scan_cnt_nxt;
      rep_left_r <= rep_left_nxt;
      ext_prev_r <= ext_prev_nxt;
      pl_prev_r <= pl_prev_nxt;
    end
  end

  // two-entry output buffer: a receiver stall holds the sample counter, no word is lost
  logic [DATA_W-1:0] buf_r [2];
  logic [DATA_W-1:0] buf_nxt [2];
  logic wr_ptr_r, wr_ptr_nxt;
  logic rd_ptr_r, rd_ptr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic pop;

  assign fifo_in_ready = (cnt_r != 2'h2);
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    buf_nxt = buf_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt = cnt_r;
    if (emit)
    begin
      buf_nxt[wr_ptr_r] = {cur_seg_r, pos_r, gain};
      wr_ptr_nxt = ~wr_ptr_r;
    end
    if (pop)
    begin
      rd_ptr_nxt = ~rd_ptr_r;
    end
    cnt_nxt = cnt_r + {1'b0, emit} - {1'b0, pop};
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      buf_r <= buf_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign out_valid_out = (cnt_r != 2'h0);
  assign {out_seg_out, out_pos_out, out_gain_out} = buf_r[rd_ptr_r];
  assign cur_seg_out = cur_seg_r;
  assign cur_entry_out = entry_r;
  assign gap_out = (st_r == ST_GAP);
  assign blank_out = (st_r == ST_BLANK);
  assign pending_out = pend_r;
  assign fallback_out = (mode_eff != mode_in);

endmodule : msc_switch_ctrl

// file: verification/msc_switch_ctrl_assertions.sv
// checker for the switch control block, bound to its top module
// assumes the short gap counts that the bench hands to the design
`timescale 1ns/1ps
module msc_switch_ctrl_assertions
  import msc_pkg::*;
#(
  parameter int GAP_EQ_CYC = 8,
  parameter int GAP_DIFF_CYC = 16
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic rates_equal_in,
  input wire logic src_ext_in,
  input wire logic exec_switch_in,
  input wire logic [SEG_W-1:0] target_seg_in,
  input wire logic [SEG_W-1:0] last_seg_in,
  input wire logic out_ready_in,
  input logic out_valid_out,
  input logic [SEG_W-1:0] out_seg_out,
  input logic [POS_W-1:0] out_pos_out,
  input logic [SEG_W-1:0] cur_seg_out,
  input logic gap_out,
  input logic pending_out,
  input logic fallback_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_hold_ignore; mode_in == MODE_HOLD && exec_switch_in && $stable(target_seg_in) && !gap_out |=> !gap_out;
  endproperty
  a_hold_ignore: assert property (p_hold_ignore) else $error("gap after ignored trigger");
  property p_abrupt_gap; mode_in == MODE_ABRUPT && !src_ext_in && exec_switch_in && !gap_out |=> gap_out; endproperty
  a_abrupt_gap: assert property (p_abrupt_gap) else $error("no gap after switch command");
  property p_gap_eq; $rose(gap_out) && rates_equal_in |-> ##GAP_EQ_CYC $fell(gap_out); endproperty
  a_gap_eq: assert property (p_gap_eq) else $error("gap length wrong, equal rates");
  property p_gap_diff; $rose(gap_out) && !rates_equal_in |-> ##GAP_DIFF_CYC $fell(gap_out); endproperty
  a_gap_diff: assert property (p_gap_diff) else $error("gap length wrong, unequal rates");
  property p_load_target; $fell(gap_out) && !src_ext_in |=> cur_seg_out == target_seg_in && !gap_out; endproperty
  a_load_target: assert property (p_load_target) else $error("wrong segment after gap");
  property p_ext_wrap;
    $fell(gap_out) && src_ext_in && mode_in == MODE_ABRUPT |=>
      cur_seg_out == ($past(cur_seg_out) == last_seg_in ? RST_SEG : $past(cur_seg_out) + 4'h1);
  endproperty
  a_ext_wrap: assert property (p_ext_wrap) else $error("external step wrong");
  property p_gapless_end; mode_in == MODE_GAPLESS && rates_equal_in && $changed(cur_seg_out) |-> $past(pending_out);
  endproperty
  a_gapless_end: assert property (p_gapless_end) else $error("gapless switch without pending");
  property p_gapless_loop;
    mode_in == MODE_GAPLESS && rates_equal_in && !src_ext_in && !exec_switch_in && $stable(target_seg_in) && !pending_out
      |=> !pending_out;
  endproperty
  a_gapless_loop: assert property (p_gapless_loop) else $error("pending without request");
  property p_fallback; fallback_out == (!rates_equal_in && mode_in[1]); endproperty
  a_fallback: assert property (p_fallback) else $error("fallback flag wrong");
  property p_pl_refuse; mode_in == MODE_PLAYLIST && rates_equal_in && exec_switch_in && !gap_out |=> !gap_out;
  endproperty
  a_pl_refuse: assert property (p_pl_refuse) else $error("command acted on in play-list");
  property p_buf_hold; out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_seg_out) && $stable(out_pos_out);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("stalled word lost");
endmodule : msc_switch_ctrl_assertions
bind msc_switch_ctrl msc_switch_ctrl_assertions #(.GAP_EQ_CYC(GAP_EQ_CYC), .GAP_DIFF_CYC(GAP_DIFF_CYC)) i_chk (
  .clk_in, .reset_n_in, .mode_in, .rates_equal_in, .src_ext_in, .exec_switch_in, .target_seg_in, .last_seg_in,
  .out_ready_in, .out_valid_out, .out_seg_out, .out_pos_out, .cur_seg_out, .gap_out, .pending_out, .fallback_out);

// file: verification/msc_far_end.sv
// far-end model: slow or prompt word receiver and connector trigger source
// assumes the bench changes stall_in and fire_in just after a rising edge
`timescale 1ns/1ps
module msc_far_end
  import msc_pkg::*;
(
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic fire_in,
  input wire logic [USEL_W-1:0] user_sel_in,
  output logic ready_out,
  output logic [NUM_USER-1:0] user_conn_out
);
  logic [1:0] beat_r = 2'h0;
  logic [NUM_USER-1:0] noise_r = 4'h0;
  logic hit_r = 1'b0;
  always_ff @(posedge clk_in)
  begin
    beat_r <= beat_r + 2'h1;
    noise_r <= ~noise_r;
    hit_r <= fire_in;
  end
  // a slow receiver takes one word in four
  assign ready_out = !stall_in || beat_r == 2'h3;
  // unselected connectors toggle so a wrong selection shows up as extra switches
  assign user_conn_out = (noise_r & ~(4'h1 << user_sel_in)) | ({3'h0, fire_in | hit_r} << user_sel_in);
endmodule : msc_far_end

// file: verification/msc_switch_ctrl_bench.sv
// self-checking bench: drives the control ports, collects the words taken by the far end
// assumes gap counts shortened to 8 and 16 cycles
`timescale 1ns/1ps
module msc_switch_ctrl_bench;
  import msc_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, rates_equal_in = 1'b1, src_ext_in = 1'b0, exec_switch_in = 1'b0;
  logic level_highest_in = 1'b0, restart_in = 1'b0, seg_we_in = 1'b0, pl_we_in = 1'b0, pl_en_in = 1'b0;
  logic stall = 1'b0, fire = 1'b0, out_ready_in, out_valid_out, gap_out, blank_out, pending_out, fallback_out;
  logic [1:0] mode_in = MODE_HOLD, pl_next_in = NXT_NEXT, user_sel_in = 2'h2;
  logic [NUM_USER-1:0] user_conn_in;
  logic [SEG_W-1:0] target_seg_in = 4'h0, last_seg_in = 4'h3, seg_idx_in = 4'h0, pl_seg_in = 4'h0;
  logic [SEG_W-1:0] out_seg_out, cur_seg_out;
  logic [POS_W-1:0] seg_len_in = 16'h0, out_pos_out;
  logic [GAIN_W-1:0] seg_crest_in = 8'h0, out_gain_out;
  logic [PL_W-1:0] pl_idx_in = 6'h0, cur_entry_out;
  logic [REP_W-1:0] pl_rep_in = 8'h0;
  logic [JUMP_W-1:0] jump_to_entry_in = 5'h0;
  logic [DATA_W-1:0] q[$];
  int n_fail = 0, samples_checked = 0, k;
  msc_switch_ctrl #(.GAP_EQ_CYC(8), .GAP_DIFF_CYC(16)) i_msc_switch_ctrl (.clk_in, .reset_n_in, .mode_in,
    .rates_equal_in, .src_ext_in, .user_sel_in, .user_conn_in, .exec_switch_in, .target_seg_in, .last_seg_in,
    .level_highest_in, .restart_in, .seg_we_in, .seg_idx_in, .seg_len_in, .seg_crest_in, .pl_we_in, .pl_idx_in,
    .pl_en_in, .pl_seg_in, .pl_rep_in, .pl_next_in, .jump_to_entry_in, .out_ready_in, .out_valid_out, .out_seg_out,
    .out_pos_out, .out_gain_out, .cur_seg_out, .cur_entry_out, .gap_out, .blank_out, .pending_out, .fallback_out);
  msc_far_end i_msc_far_end (.clk_in, .stall_in(stall), .fire_in(fire), .user_sel_in, .ready_out(out_ready_in),
    .user_conn_out(user_conn_in));
  initial
  begin
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    if (out_valid_out === 1'b1 && out_ready_in === 1'b1) q.push_back({out_seg_out, out_pos_out, out_gain_out});
  end
  task wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  task wait_seg(input logic [SEG_W-1:0] s);
    int i;
    for (i = 0; i < 300 && cur_seg_out !== s; i++) tick(1);
    cmp(cur_seg_out, s);
    if (i == 300) wrap_up();
  endtask : wait_seg
  // pl_we_in is held by the caller across back-to-back entries
  task wr_pl(input int i, input logic en, input logic [3:0] s, input logic [7:0] r, input logic [1:0] nx);
    pl_idx_in = 6'(i);
    pl_en_in = en;
    pl_seg_in = s;
    pl_rep_in = r;
    pl_next_in = nx;
    jump_to_entry_in = 5'h4;
    tick(1);
  endtask : wr_pl
  initial
  begin
    #1;
    seg_we_in = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      seg_idx_in = 4'(k);
      seg_len_in = 16'(k + 3);
      seg_crest_in = 8'(16 * k + 16);
      tick(1);
    end
    seg_we_in = 1'b0;
    tick(1);
    reset_n_in = 1'b1;
    q.delete();
    tick(14);
    for (k = 0; k < 6; k++) cmp(q[k], {4'h0, 16'(k % 3), 8'h10});
    pulse(exec_switch_in);
    tick(3);
    cmp(gap_out, 1'b0);
    target_seg_in = 4'h2;
    wait_seg(4'h2);
    mode_in = MODE_ABRUPT;
    reset_n_in = 1'b0;
    tick(2);
    reset_n_in = 1'b1;
    tick(3);
    cmp(cur_seg_out, 4'h0);
    target_seg_in = 4'h1;
    tick(4);
    cmp(gap_out, 1'b0);
    pulse(exec_switch_in);
    wait_seg(4'h1);
    src_ext_in = 1'b1;
    rates_equal_in = 1'b0;
    pulse(exec_switch_in);
    tick(30);
    cmp(cur_seg_out, 4'h1);
    for (k = 2; k < 5; k++)
    begin
      pulse(fire);
      wait_seg(4'(k % 4));
    end
    rates_equal_in = 1'b1;
    src_ext_in = 1'b0;
    target_seg_in = 4'h0;
    level_highest_in = 1'b1;
    tick(4);
    q.delete();
    tick(8);
    cmp(q[2][7:0], 8'h40);
    mode_in = MODE_GAPLESS;
    stall = 1'b1;
    tick(40);
    cmp(pending_out, 1'b0);
    cmp(cur_seg_out, 4'h0);
    target_seg_in = 4'h3;
    tick(2);
    cmp(pending_out, 1'b1);
    wait_seg(4'h3);
    tick(20);
    k = 1;
    while (k < q.size() && q[k][27:24] !== 4'h3) k++;
    cmp(q[k - 1], {4'h0, 16'h2, 8'h40});
    cmp(q[k], {4'h3, 16'h0, 8'h40});
    stall = 1'b0;
    rates_equal_in = 1'b0;
    tick(1);
    cmp(fallback_out, 1'b1);
    rates_equal_in = 1'b1;
    pl_we_in = 1'b1;
    wr_pl(0, 1'b1, 4'h2, 8'h1, NXT_NEXT);
    wr_pl(1, 1'b0, 4'h0, 8'h1, NXT_NEXT);
    wr_pl(2, 1'b1, 4'h3, 8'h2, NXT_JUMP);
    wr_pl(3, 1'b0, 4'h0, 8'h1, NXT_NEXT);
    wr_pl(4, 1'b1, 4'h1, 8'h1, NXT_BLANK);
    pl_we_in = 1'b0;
    mode_in = MODE_PLAYLIST;
    q.delete();
    exec_switch_in = 1'b1;
    src_ext_in = 1'b1;
    pulse(fire);
    exec_switch_in = 1'b0;
    tick(60);
    while (q.size() > 0 && q[0][27:24] !== 4'h2) void'(q.pop_front());
    for (k = 0; k < 21; k++) cmp(q[k][27:24], k < 5 ? 4'h2 : k < 17 ? 4'h3 : 4'h1);
    cmp(DATA_W'(q.size()), 28'h15);
    cmp(blank_out, 1'b1);
    cmp(cur_entry_out, 6'h04);
    pl_we_in = 1'b1;
    wr_pl(4, 1'b1, 4'h1, 8'h1, NXT_ENDLESS);
    pl_we_in = 1'b0;
    q.delete();
    pulse(restart_in);
    tick(60);
    cmp(q[0][27:24], 4'h2);
    cmp(q[40][27:24], 4'h1);
    cmp(blank_out, 1'b0);
    cmp(cur_entry_out, 6'h04);
    wrap_up();
  end
  // a hang anywhere ends in the same report
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule : msc_switch_ctrl_bench
